// ### hw/dtr_defs.svh
// constants for the tuning register core: word layout, control bits, timing
// assumes: included by bare name from the package only; both ends rely on its macros
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH

// ========================================
// serial word layout
`define DTR_WORD_W 16
`define DTR_DEST_HI 15
`define DTR_DEST_LO 14
`define DTR_HALF_W 14
`define DTR_OFS_ID 13
`define DTR_OFS_HI 11

// ========================================
// control word bit positions
`define DTR_B_FULL 13
`define DTR_B_UPPER 12
`define DTR_B_TSEL 11
`define DTR_B_OSEL 10
`define DTR_B_SRC 9
`define DTR_B_RST 8
`define DTR_B_GATE 7
`define DTR_B_PDN 6

// ========================================
// widths, reset values and timing
`define DTR_TUNE_W 28
`define DTR_OFS_W 12
`define DTR_CTRL_RST 16'h0000
`define DTR_OUT_LAT 7
`define DTR_SCLK_DIV 4

// ========================================
// host register offsets and pin field positions
`define DTR_REG_CMD 4'h0
`define DTR_REG_STATUS 4'h1
`define DTR_REG_PINS 4'h2
`define DTR_P_TSEL 0
`define DTR_P_OSEL 1
`define DTR_P_RST 2
`define DTR_P_SLEEP 3
`define DTR_PINS_RST 4'h4

`endif

// ### hw/dtr_pkg.sv
// types shared by both ends of the tuning register link
// assumes: nothing beyond the constants header
`include "dtr_defs.svh"
package dtr_pkg;
    // destination code held in the top two bits of each serial word
    typedef enum logic [1:0] {
        DTR_DEST_CTRL = 2'h0,
        DTR_DEST_TUNE_A = 2'h1,
        DTR_DEST_TUNE_B = 2'h2,
        DTR_DEST_OFS = 2'h3
    } dtr_dest_t;

    // host serialiser states
    typedef enum logic [1:0] {
        DTR_H_IDLE,
        DTR_H_SHIFT,
        DTR_H_TAIL
    } dtr_host_state_t;
endpackage

// ### hw/dtr_link_if.sv
// pins between the host and the tuning register core
// assumes: host drives every pin, device only reads
interface dtr_link_if;
    logic sclk;
    logic fsync_n;
    logic serial_input;
    logic tune_select_pin;
    logic offset_select_pin;
    logic reset_pin;
    logic sleep_pin;

    modport host (
        output sclk, fsync_n, serial_input, tune_select_pin,
        output offset_select_pin, reset_pin, sleep_pin
    );
    modport dev (
        input sclk, fsync_n, serial_input, tune_select_pin,
        input offset_select_pin, reset_pin, sleep_pin
    );
endinterface

// ### hw/dtr_device.sv
// tuning register core: serial receiver, word and offset registers,
// selection, phase accumulator, reset and sleep handling
// assumes: link pins are asynchronous to clk_sys_i; clk_sys_i is the master clock
//
// Operation
// - two 28-bit tuning words held
// - two 12-bit offsets added after accumulator
// - 28-bit accumulator adds selected word each cycle
// - offset step is one 4096th cycle
// - source bit picks pins or select bits
// - source may change at any time
// - select pins sampled once per clock
// - codes 01/10 load tuning word a/b
// - code 00 writes control word
// - full load: low half then high
// - half mode: upper bit picks half
// - code 11 loads offset, bit 13 picks
// - reset clears accumulator, keeps registers
// - output valid seven cycles after release
// - reset source follows source bit
// - reset pin acts at once, release sampled
// - host asserts reset pin at power-up; ignored in bit mode
// - pin mode: sleep pin powers converter down
// - bit mode: gate and powerdown independent
// - control bits at fixed word positions
// - gated clock holds accumulator, writes continue
// - sleep pin acts at once, release sampled
//
// Chosen here: the register addresses and the strobed register port.
module dtr_device
    import dtr_pkg::*;
#(
    parameter int OUT_LAT = `DTR_OUT_LAT
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // link from the host
    dtr_link_if.dev link,
    // phase path
    output logic [`DTR_OFS_W-1:0] phase_word_o,
    output logic output_valid_o,
    output logic [`DTR_TUNE_W-1:0] selected_tuning_value_o,
    output logic [`DTR_OFS_W-1:0] selected_offset_value_o,
    // power and reset state
    output logic in_reset_o,
    output logic converter_pdn_o,
    output logic clock_gated_o
);
    // ========================================
    // pin synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic sclk_s, fsync_s, serial_input_s, tsel_s, osel_s, rst_s, sleep_s;

    assign pin_raw = {link.sleep_pin, link.reset_pin, link.offset_select_pin,
                      link.tune_select_pin, link.serial_input, link.fsync_n, link.sclk};
    assign {sleep_s, rst_s, osel_s, tsel_s, serial_input_s, fsync_s, sclk_s} = sync_ff;

    // two flops on every pin before use, except the raw reset and sleep pin paths
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_ff <= 7'h7f;
            sync_ff <= 7'h7f;
        end
        else
        begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
        end
    end

    // ========================================
    // serial receiver
    logic sclk_dly_ff;
    logic [3:0] bit_cnt_ff;
    logic [`DTR_WORD_W-2:0] shift_ff;
    logic [`DTR_WORD_W-1:0] word_ff;
    logic word_done_ff;
    logic sclk_fall;

    assign sclk_fall = sclk_dly_ff & ~sclk_s;

    // shift on each falling serial clock inside a frame
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk_dly_ff <= 1'b1;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 15'h0000;
            word_ff <= 16'h0000;
            word_done_ff <= 1'b0;
        end
        else
        begin
            sclk_dly_ff <= sclk_s;
            word_done_ff <= 1'b0;
            if (fsync_s)
                bit_cnt_ff <= 4'h0; // a frame cut short is dropped
            else if (sclk_fall)
            begin
                shift_ff <= {shift_ff[`DTR_WORD_W-3:0], serial_input_s};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (bit_cnt_ff == 4'hf)
                begin
                    word_ff <= {shift_ff, serial_input_s};
                    word_done_ff <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // word, offset and control registers
    logic [`DTR_TUNE_W-1:0] tune_ff [2];
    logic [`DTR_OFS_W-1:0] ofs_ff [2];
    logic [`DTR_WORD_W-1:0] ctrl_ff;
    logic [`DTR_HALF_W-1:0] stage_ff;
    logic pend_ff;
    logic pend_idx_ff;
    dtr_dest_t dest;
    logic [`DTR_HALF_W-1:0] half;
    logic widx;

    assign dest = dtr_dest_t'(word_ff[`DTR_DEST_HI:`DTR_DEST_LO]);
    assign half = word_ff[`DTR_HALF_W-1:0];
    assign widx = (dest == DTR_DEST_TUNE_B);

    // apply a finished word to its destination; internal reset leaves these alone
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tune_ff[0] <= 28'h000_0000;
            tune_ff[1] <= 28'h000_0000;
            ofs_ff[0] <= 12'h000;
            ofs_ff[1] <= 12'h000;
            ctrl_ff <= `DTR_CTRL_RST;
            stage_ff <= 14'h0000;
            pend_ff <= 1'b0;
            pend_idx_ff <= 1'b0;
        end
        else if (word_done_ff)
        begin
            case (dest)
                DTR_DEST_CTRL:
                begin
                    ctrl_ff <= word_ff;
                    pend_ff <= 1'b0;
                end
                DTR_DEST_TUNE_A, DTR_DEST_TUNE_B:
                begin
                    if (ctrl_ff[`DTR_B_FULL])
                    begin
                        if (pend_ff && (pend_idx_ff == widx))
                        begin
                            tune_ff[widx] <= {half, stage_ff};
                            pend_ff <= 1'b0;
                        end
                        else
                        begin
                            stage_ff <= half;
                            pend_ff <= 1'b1;
                            pend_idx_ff <= widx;
                        end
                    end
                    else if (ctrl_ff[`DTR_B_UPPER])
                        tune_ff[widx][`DTR_TUNE_W-1:`DTR_HALF_W] <= half;
                    else
                        tune_ff[widx][`DTR_HALF_W-1:0] <= half;
                end
                DTR_DEST_OFS:
                    ofs_ff[word_ff[`DTR_OFS_ID]] <= word_ff[`DTR_OFS_HI:0];
                default:
                    pend_ff <= pend_ff;
            endcase
        end
    end

    // ========================================
    // selection, reset and sleep sources
    logic src_pin;
    logic tsel;
    logic osel;
    logic rst_hold;
    logic gate;

    assign src_pin = ctrl_ff[`DTR_B_SRC];
    assign tsel = src_pin ? tsel_s : ctrl_ff[`DTR_B_TSEL];
    assign osel = src_pin ? osel_s : ctrl_ff[`DTR_B_OSEL];
    assign rst_hold = src_pin ? rst_s : ctrl_ff[`DTR_B_RST];
    assign gate = ~src_pin & ctrl_ff[`DTR_B_GATE];
    assign selected_tuning_value_o = tune_ff[tsel];
    assign selected_offset_value_o = ofs_ff[osel];

    // raw pin rise acts at once; the fall waits for the synchronised copy
    assign in_reset_o = rst_hold | (src_pin & link.reset_pin);
    assign converter_pdn_o = src_pin ? (link.sleep_pin | sleep_s) : ctrl_ff[`DTR_B_PDN];
    assign clock_gated_o = gate;

    // ========================================
    // phase accumulator and offset adder
    logic [`DTR_TUNE_W-1:0] acc_ff;
    logic [`DTR_OFS_W-1:0] phase_ff;
    logic [3:0] lat_cnt_ff;

    // accumulate, hold while gated, clear under internal reset
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            acc_ff <= 28'h000_0000;
        else if (rst_hold)
            acc_ff <= 28'h000_0000;
        else if (!gate)
            acc_ff <= acc_ff + selected_tuning_value_o;
    end

    // top 12 bits plus offset, wrapping mod one cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            phase_ff <= 12'h000;
        else if (rst_hold)
            phase_ff <= 12'h000;
        else if (!gate)
            phase_ff <= acc_ff[`DTR_TUNE_W-1:`DTR_TUNE_W-`DTR_OFS_W] + selected_offset_value_o;
    end

    // output latency after reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            lat_cnt_ff <= 4'h0;
        else if (rst_hold)
            lat_cnt_ff <= 4'h0;
        else if (!gate && (lat_cnt_ff != 4'(OUT_LAT)))
            lat_cnt_ff <= lat_cnt_ff + 4'h1;
    end

    assign output_valid_o = (lat_cnt_ff == 4'(OUT_LAT)) & ~in_reset_o;
    assign phase_word_o = in_reset_o ? 12'h000 : phase_ff;
endmodule

// ### hw/dtr_host.sv
// host end: register port for software, serialiser and pin drivers
// assumes: device synchronises every pin; divider keeps half periods >= 2 clocks
module dtr_host
    import dtr_pkg::*;
#(
    parameter int SCLK_DIV = `DTR_SCLK_DIV
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // software register port
    input wire logic [3:0] addr_i,
    input wire logic [`DTR_WORD_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`DTR_WORD_W-1:0] rdata_o,
    // link to the device
    dtr_link_if.host link
);
    // ========================================
    // pin register and read port
    logic [3:0] pins_ff;
    logic [`DTR_WORD_W-1:0] rdata_ff;
    logic busy;

    // pins start with reset asserted; the device ignores the pin until its source bit selects pins
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pins_ff <= `DTR_PINS_RST;
        else if (we_i && (addr_i == `DTR_REG_PINS))
            pins_ff <= wdata_i[3:0];
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_ff <= 16'h0000;
        else if (re_i)
        begin
            case (addr_i)
                `DTR_REG_STATUS: rdata_ff <= {15'h0000, busy};
                `DTR_REG_PINS: rdata_ff <= {12'h000, pins_ff};
                default: rdata_ff <= 16'h0000;
            endcase
        end
    end

    assign rdata_o = rdata_ff;
    assign link.tune_select_pin = pins_ff[`DTR_P_TSEL];
    assign link.offset_select_pin = pins_ff[`DTR_P_OSEL];
    assign link.reset_pin = pins_ff[`DTR_P_RST];
    assign link.sleep_pin = pins_ff[`DTR_P_SLEEP];

    // ========================================
    // serial clock divider
    logic [7:0] div_ff;
    logic tick;

    assign tick = (div_ff == 8'(SCLK_DIV - 1));

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_ff <= 8'h00;
        else if (tick)
            div_ff <= 8'h00;
        else
            div_ff <= div_ff + 8'h01;
    end

    // ========================================
    // serialiser: msb first, data changes while sclk is high
    dtr_host_state_t state_ff;
    logic [`DTR_WORD_W-1:0] shift_ff;
    logic [3:0] bits_ff;
    logic sclk_ff;
    logic fsync_n_ff;

    assign busy = (state_ff != DTR_H_IDLE);

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= DTR_H_IDLE;
            shift_ff <= 16'h0000;
            bits_ff <= 4'h0;
            sclk_ff <= 1'b1;
            fsync_n_ff <= 1'b1;
        end
        else
        begin
            case (state_ff)
                DTR_H_IDLE:
                begin
                    // a command write while busy is ignored
                    if (we_i && (addr_i == `DTR_REG_CMD))
                    begin
                        shift_ff <= wdata_i;
                        bits_ff <= 4'h0;
                        fsync_n_ff <= 1'b0;
                        state_ff <= DTR_H_SHIFT;
                    end
                end
                DTR_H_SHIFT:
                begin
                    if (tick)
                    begin
                        if (sclk_ff)
                            sclk_ff <= 1'b0; // device samples here
                        else
                        begin
                            sclk_ff <= 1'b1;
                            shift_ff <= {shift_ff[`DTR_WORD_W-2:0], 1'b0};
                            bits_ff <= bits_ff + 4'h1;
                            if (bits_ff == 4'hf)
                                state_ff <= DTR_H_TAIL;
                        end
                    end
                end
                DTR_H_TAIL:
                begin
                    if (tick)
                    begin
                        fsync_n_ff <= 1'b1;
                        state_ff <= DTR_H_IDLE;
                    end
                end
                default:
                    state_ff <= DTR_H_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_ff;
    assign link.fsync_n = fsync_n_ff;
    assign link.serial_input = shift_ff[`DTR_WORD_W-1];
endmodule

// ### tb/dtr_properties.sv
// checker for the tuning register link and the device outputs
// assumes: instantiated beside the link interface, one clock domain
module dtr_properties (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // link pins
    input wire logic sclk,
    input wire logic fsync_n,
    input wire logic reset_pin,
    input wire logic sleep_pin,
    // device outputs
    input wire logic [11:0] phase_word_o,
    input wire logic output_valid_o,
    input wire logic [27:0] selected_tuning_value_o,
    input wire logic in_reset_o,
    input wire logic converter_pdn_o,
    input wire logic clock_gated_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // link framing and register update
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    property p_frame_close;
        $rose(fsync_n) |-> sclk;
    endproperty
    a_frame_close: assert property (p_frame_close) else $error("frame closed with serial clock low");

    property p_frame_stable;
        $fell(fsync_n) |-> $stable(selected_tuning_value_o)[*8];
    endproperty
    a_frame_stable: assert property (p_frame_stable) else $error("tuning word moved before word end");

    // ========================================
    // reset, latency and sleep
    property p_valid_lat;
        $fell(in_reset_o) |-> (!output_valid_o)[*6] ##[1:3] output_valid_o;
    endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("output valid latency wrong");

    property p_valid_off;
        in_reset_o |-> !output_valid_o;
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("output valid during reset");

    property p_phase_zero;
        in_reset_o && $past(in_reset_o) |-> phase_word_o == 12'h000;
    endproperty
    a_phase_zero: assert property (p_phase_zero) else $error("phase not cleared in reset");

    property p_rst_release;
        $fell(reset_pin) && in_reset_o |=> in_reset_o;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset release not sampled");

    property p_sleep_release;
        $fell(sleep_pin) && converter_pdn_o |=> converter_pdn_o;
    endproperty
    a_sleep_release: assert property (p_sleep_release) else $error("sleep release not sampled");

    property p_gate_hold;
        clock_gated_o && $past(clock_gated_o) && !in_reset_o && !$past(in_reset_o) |-> $stable(phase_word_o);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("phase moved while clock gated");
endmodule

// ### tb/test_dds_tuning_register_control.sv
// self-checking bench: host and device joined by the link interface
// assumes: host register map 0 command, 1 status, 2 pins
module test_dds_tuning_register_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // signals
    logic clk_sys_i;
    logic rstn_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    logic we_i;
    logic re_i;
    logic [15:0] rdata_o;
    logic [11:0] phase_word_o;
    logic output_valid_o;
    logic [27:0] selected_tuning_value_o;
    logic [11:0] selected_offset_value_o;
    logic in_reset_o;
    logic converter_pdn_o;
    logic clock_gated_o;
    int failures = 0;
    int n_checks = 0;

    // ========================================
    // both ends and the checker
    dtr_link_if link();
    dtr_host #(.SCLK_DIV(8)) u_dtr_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .link(link));
    dtr_device #(.OUT_LAT(7)) u_dtr_device (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link),
        .phase_word_o(phase_word_o), .output_valid_o(output_valid_o),
        .selected_tuning_value_o(selected_tuning_value_o), .selected_offset_value_o(selected_offset_value_o),
        .in_reset_o(in_reset_o), .converter_pdn_o(converter_pdn_o), .clock_gated_o(clock_gated_o));
    dtr_properties u_dtr_properties (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk(link.sclk),
        .fsync_n(link.fsync_n), .reset_pin(link.reset_pin), .sleep_pin(link.sleep_pin),
        .phase_word_o(phase_word_o), .output_valid_o(output_valid_o),
        .selected_tuning_value_o(selected_tuning_value_o), .in_reset_o(in_reset_o),
        .converter_pdn_o(converter_pdn_o), .clock_gated_o(clock_gated_o));

    // 125 MHz clock
    always #4 clk_sys_i = ~clk_sys_i;

    // ========================================
    // shared tasks
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_sys_i);
        we_i <= 1'b0;
    endtask

    // read data stands from the cycle after the strobe until the next read strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_sys_i);
        re_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask

    // one serial word, then poll busy and let the device apply it
    task automatic send(input logic [15:0] w);
        logic [15:0] s;
        wr(4'h0, w);
        s = 16'h0001;
        for (int i = 0; i < 300 && s[0] === 1'b1; i++)
            rd(4'h1, s);
        chk(28'(s[0]), 28'h000_0000);
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic pins(input logic [15:0] v);
        wr(4'h2, v);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    // ========================================
    // scenarios
    task automatic t_regs;
        logic [15:0] d;
        rd(4'h2, d);
        chk(28'(d), 28'h000_0004);
        rd(4'hf, d);
        chk(28'(d), 28'h000_0000);
        wr(4'h2, 16'h0003);
        rd(4'h2, d);
        chk(28'(d), 28'h000_0003);
        pins(16'h0000);
        $display("test regs done");
    endtask

    task automatic t_words;
        send(16'h2000);
        send(16'h5234);
        send(16'h4abc);
        chk(selected_tuning_value_o, 28'h2af_1234);
        send(16'hbfff);
        send(16'h8001);
        chk(selected_tuning_value_o, 28'h2af_1234);
        send(16'h2800);
        chk(selected_tuning_value_o, 28'h000_7fff);
        send(16'h1000);
        send(16'h4055);
        chk(selected_tuning_value_o, 28'h015_5234);
        send(16'h0000);
        send(16'h4f0f);
        chk(selected_tuning_value_o, 28'h015_4f0f);
        send(16'hdabc);
        send(16'he123);
        chk(28'(selected_offset_value_o), 28'h000_0abc);
        send(16'h0400);
        chk(28'(selected_offset_value_o), 28'h000_0123);
        $display("test words done");
    endtask

    task automatic t_select;
        send(16'h0200);
        chk(selected_tuning_value_o, 28'h015_4f0f);
        pins(16'h0001);
        chk(selected_tuning_value_o, 28'h000_7fff);
        chk(28'(selected_offset_value_o), 28'h000_0abc);
        send(16'h0400);
        chk(selected_tuning_value_o, 28'h015_4f0f);
        chk(28'(selected_offset_value_o), 28'h000_0123);
        $display("test select done");
    endtask

    // pin reset, bit reset, and latency back to a valid output
    task automatic t_reset;
        int n;
        send(16'h0200);
        // the raw pin must act before its synchronised copy arrives
        wr(4'h2, 16'h0004);
        @(negedge clk_sys_i);
        chk(28'(in_reset_o), 28'h000_0001);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(28'({in_reset_o, output_valid_o}), 28'h000_0002);
        chk(28'(phase_word_o), 28'h000_0000);
        pins(16'h0000);
        for (n = 0; n < 30 && output_valid_o !== 1'b1; n++)
            @(negedge clk_sys_i);
        // two sync flops plus seven counted clocks, less the six already waited
        chk(28'(n), 28'h000_0003);
        chk(selected_tuning_value_o, 28'h015_4f0f);
        send(16'h0300);
        chk(28'(in_reset_o), 28'h000_0000);
        send(16'h0100);
        chk(28'(in_reset_o), 28'h000_0001);
        send(16'h2000);
        $display("test reset done");
    endtask

    // zero word keeps the accumulator at 0, so phase equals the offset
    task automatic t_phase;
        logic [11:0] p0;
        send(16'h4000);
        send(16'h4000);
        send(16'h2100);
        send(16'h2000);
        chk(28'(phase_word_o), 28'h000_0abc);
        send(16'h4000);
        send(16'h4004);
        p0 = phase_word_o;
        @(negedge clk_sys_i);
        chk(28'(12'(phase_word_o - p0)), 28'h000_0001);
        $display("test phase done");
    endtask

    task automatic t_sleep;
        logic [11:0] p0;
        send(16'h0040);
        chk(28'({converter_pdn_o, clock_gated_o}), 28'h000_0002);
        send(16'h0080);
        p0 = phase_word_o;
        send(16'h4008);
        chk(28'(phase_word_o), 28'(p0));
        chk(selected_tuning_value_o, 28'h001_0008);
        send(16'h00c0);
        chk(28'({converter_pdn_o, clock_gated_o}), 28'h000_0003);
        send(16'h02c0);
        chk(28'({converter_pdn_o, clock_gated_o}), 28'h000_0000);
        // sleep pin rise must power down before the synchronised copy
        wr(4'h2, 16'h0008);
        @(negedge clk_sys_i);
        chk(28'(converter_pdn_o), 28'h000_0001);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(28'({converter_pdn_o, clock_gated_o}), 28'h000_0002);
        pins(16'h0000);
        chk(28'(converter_pdn_o), 28'h000_0000);
        $display("test sleep done");
    endtask

    // ========================================
    // verdict and run control
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the expected run of some 8300 clocks
    initial
    begin
        #400us;
        failures++;
        conclude();
    end

    // reset, then the scenarios in order
    initial
    begin
        clk_sys_i = 1'b0;
        rstn_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        we_i = 1'b0;
        re_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_regs();
        t_words();
        t_select();
        t_reset();
        t_phase();
        t_sleep();
        conclude();
    end
endmodule
